// ==== rtl/spimio_consts.svh ====
// Constants of the multi-I/O pin function selector.
// Assumes inclusion by bare name from the rtl folder.
`ifndef SPIMIO_CONSTS_SVH
`define SPIMIO_CONSTS_SVH

// Lane positions on the four shared pins
`define SPIMIO_LANE_ZERO 0
`define SPIMIO_LANE_ONE 1
`define SPIMIO_LANE_TWO 2
`define SPIMIO_LANE_THREE 3

// Bits moved per clock edge at each width, and bits per byte
`define SPIMIO_STEP_SINGLE 4'h1
`define SPIMIO_STEP_DUAL 4'h2
`define SPIMIO_STEP_QUAD 4'h4
`define SPIMIO_BYTE_BITS 4'h8

// Lanes the device may drive at each width
`define SPIMIO_MASK_SINGLE 4'h2
`define SPIMIO_MASK_DUAL 4'h3
`define SPIMIO_MASK_QUAD 4'hF

// Synchroniser depths and reset values
`define SPIMIO_PIN_SYNC_STAGES 2
`define SPIMIO_PIN_SYNC_RST 3'h7
`define SPIMIO_RX_SYNC_STAGES 3
`define SPIMIO_ACK_SYNC_STAGES 2
`define SPIMIO_TGL_SYNC_RST 1'h0

`endif

// ==== rtl/spimio_pkg.sv ====
// Types of the multi-I/O pin function selector.
// Assumes nothing beyond a SystemVerilog compiler.
package spimio_pkg;

  // Transfer width of the current command phase
  typedef enum logic [1:0] {
    SPIMIO_W_SINGLE,
    SPIMIO_W_DUAL,
    SPIMIO_W_QUAD
  } spimio_width_e;

  // One transmit phase word handed from core to link
  typedef struct packed {
    logic drive;
    spimio_width_e width;
    logic [7:0] data;
  } spimio_txw_s;

endpackage

// ==== rtl/spimio_sync_if.sv ====
// Carrier between a synchroniser and its user.
// Assumes the user drives async_in and reads sync_out only.
`timescale 1ns/1ps
interface spimio_sync_if #(
  parameter int W = 1
);
  logic [W-1:0] async_in;
  logic [W-1:0] sync_out;

  modport sync (input async_in, output sync_out);
  modport user (output async_in, input sync_out);
endinterface

// ==== rtl/spimio_sync.sv ====
// Multi-stage level synchroniser into the clock of its instance.
// Assumes async_in changes slower than the destination clock.
`timescale 1ns/1ps
module spimio_sync #(
  parameter int W = 1,
  parameter int STAGES = 2,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Carrier
  spimio_sync_if.sync port
);
  typedef struct packed {
    logic [STAGES-1:0][W-1:0] stage;
  } spimio_sync_s;

  spimio_sync_s s;
  spimio_sync_s next_s;

  // Only stage 1 reads stage 0; nothing else looks at it
  always_comb begin
    next_s = s;
    next_s.stage = {s.stage[STAGES-2:0], port.async_in};
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s.stage <= {STAGES{RST_VAL}};
    end else if (i_ce) begin
      s <= next_s;
    end
  end

  assign port.sync_out = s.stage[STAGES-1];
endmodule // spimio_sync

// ==== rtl/spimio_pin_mux.sv ====
// Pin function selection of a multi-I/O serial flash interface.
// Assumes the host drives SCK and chip select, and that the two
// configuration inputs change only while the device is deselected.
//
// Contract
// - The data-in pin is a single-bit input for single-bit commands and lane_zero otherwise.
// - The data-out pin is the single-bit output for single-bit commands and lane_one otherwise.
// - The write-guard pin protects writes while quad mode is off and is lane_two when it is on.
// - The pause pin pauses transfer while quad mode is off and is lane_three when it is on.
// - With pause_or_reset_select set, lane three low is a reset when quad is off or CS is high.
// - Command, address and data move one, two or four bits per clock by command width; quad moves two while quad mode is off.
// - Inputs are sampled on the rising clock edge and outputs change after the falling edge.
// - While chip select is high data transfer is ignored and every lane floats; write guard and reset inputs still act.
// - Quad mode is on when quad_enable is 1, and then write guard and pause are unavailable.
`timescale 1ns/1ps
`include "spimio_consts.svh"
module spimio_pin_mux (
  // Core clock, reset, enable
  input wire logic I_CORE_CLK,
  input wire logic I_SRST,
  input wire logic I_CE,
  // Link pins
  input wire logic I_SCK,
  input wire logic I_CS_N,
  input wire logic [3:0] I_LANE,
  output logic [3:0] O_LANE,
  output logic [3:0] O_LANE_OE,
  // Configuration
  input wire logic I_QUAD_ENABLE,
  input wire logic I_PAUSE_OR_RESET_SELECT,
  // Transmit phase request
  input wire logic I_TX_VALID,
  input spimio_pkg::spimio_width_e I_TX_WIDTH,
  input wire logic I_TX_DRIVE,
  input wire logic [7:0] I_TX_DATA,
  output logic O_TX_READY,
  // Received bytes
  output logic O_RX_VALID,
  output logic [7:0] O_RX_DATA,
  // Pin function status
  output logic O_WRITE_PROTECT,
  output logic O_PAUSE,
  output logic O_HW_RESET,
  output logic O_SELECTED
);
  import spimio_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Width decoding

  // Quad is only honoured while quad mode is enabled
  function automatic spimio_width_e eff_width(spimio_width_e w, logic qe);
    eff_width = (w == SPIMIO_W_QUAD && !qe) ? SPIMIO_W_DUAL : w;
  endfunction

  function automatic logic [3:0] step_of(spimio_width_e w);
    unique case (w)
      SPIMIO_W_SINGLE: step_of = `SPIMIO_STEP_SINGLE;
      SPIMIO_W_DUAL: step_of = `SPIMIO_STEP_DUAL;
      SPIMIO_W_QUAD: step_of = `SPIMIO_STEP_QUAD;
      default: step_of = `SPIMIO_STEP_SINGLE;
    endcase
  endfunction

  function automatic logic [3:0] mask_of(spimio_width_e w);
    unique case (w)
      SPIMIO_W_SINGLE: mask_of = `SPIMIO_MASK_SINGLE;
      SPIMIO_W_DUAL: mask_of = `SPIMIO_MASK_DUAL;
      SPIMIO_W_QUAD: mask_of = `SPIMIO_MASK_QUAD;
      default: mask_of = 4'h0;
    endcase
  endfunction

  // Higher lane carries the earlier, more significant bit
  function automatic logic [7:0] shift_in(logic [7:0] s, logic [3:0] p, spimio_width_e w);
    unique case (w)
      SPIMIO_W_SINGLE: shift_in = {s[6:0], p[`SPIMIO_LANE_ZERO]};
      SPIMIO_W_DUAL: shift_in = {s[5:0], p[`SPIMIO_LANE_ONE], p[`SPIMIO_LANE_ZERO]};
      SPIMIO_W_QUAD: shift_in = {s[3:0], p};
      default: shift_in = s;
    endcase
  endfunction

  function automatic logic [3:0] out_bits(logic [7:0] s, spimio_width_e w);
    unique case (w)
      SPIMIO_W_SINGLE: out_bits = {2'h0, s[7], 1'h0};
      SPIMIO_W_DUAL: out_bits = {2'h0, s[7], s[6]};
      SPIMIO_W_QUAD: out_bits = s[7:4];
      default: out_bits = 4'h0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State types

  typedef struct packed {
    logic qe;
    logic psel;
    spimio_txw_s tx_word;
    logic tx_tgl;
    logic busy;
    logic rx_seen;
    logic rx_valid;
    logic [7:0] rx_data;
    logic wp;
    logic pause;
    logic hw_rst;
    logic selected;
  } spimio_core_s;

  typedef struct packed {
    logic tx_s1;
    logic tx_s2;
    logic tx_seen;
    logic ack_tgl;
    logic drive;
    spimio_width_e width;
    logic [7:0] tx_shift;
    logic [7:0] rx_shift;
    logic [3:0] cnt;
    logic [7:0] rx_byte;
    logic rx_tgl;
  } spimio_link_s;

  typedef struct packed {
    logic [3:0] bits;
    logic [3:0] oe;
    logic hold;
  } spimio_out_s;

  spimio_core_s c;
  spimio_core_s next_c;
  spimio_link_s l;
  spimio_link_s next_l;
  spimio_out_s o;
  spimio_out_s next_o;

  ////////////////////////////////////////////////////////////////////////////
  // Crossings into the core clock

  spimio_sync_if #(.W(3)) pin_if ();
  spimio_sync_if #(.W(1)) rx_if ();
  spimio_sync_if #(.W(1)) ack_if ();

  assign pin_if.async_in = {I_CS_N, I_LANE[`SPIMIO_LANE_THREE], I_LANE[`SPIMIO_LANE_TWO]};
  assign rx_if.async_in = l.rx_tgl;
  assign ack_if.async_in = l.ack_tgl;

  spimio_sync #(.W(3), .STAGES(`SPIMIO_PIN_SYNC_STAGES), .RST_VAL(`SPIMIO_PIN_SYNC_RST)) u_pin_sync (
    .i_clk(I_CORE_CLK),
    .i_rst(I_SRST),
    .i_ce(I_CE),
    .port(pin_if.sync)
  );

  // One stage deeper than chip select, so a frame end masks the toggle reset
  spimio_sync #(.W(1), .STAGES(`SPIMIO_RX_SYNC_STAGES), .RST_VAL(`SPIMIO_TGL_SYNC_RST)) u_rx_sync (
    .i_clk(I_CORE_CLK),
    .i_rst(I_SRST),
    .i_ce(I_CE),
    .port(rx_if.sync)
  );

  spimio_sync #(.W(1), .STAGES(`SPIMIO_ACK_SYNC_STAGES), .RST_VAL(`SPIMIO_TGL_SYNC_RST)) u_ack_sync (
    .i_clk(I_CORE_CLK),
    .i_rst(I_SRST),
    .i_ce(I_CE),
    .port(ack_if.sync)
  );

  logic cs_high;
  logic pause_pin;
  logic guard_pin;
  assign {cs_high, pause_pin, guard_pin} = pin_if.sync_out;

  ////////////////////////////////////////////////////////////////////////////
  // Core domain

  always_comb begin
    next_c = c;
    next_c.rx_valid = 1'h0;
    next_c.qe = I_QUAD_ENABLE;
    next_c.psel = I_PAUSE_OR_RESET_SELECT;
    if (cs_high) begin
      // Link state was cleared by chip select; drop any pending phase
      next_c.tx_tgl = 1'h0;
      next_c.busy = 1'h0;
      next_c.rx_seen = rx_if.sync_out;
    end else begin
      if (c.busy && ack_if.sync_out == c.tx_tgl) begin
        next_c.busy = 1'h0;
      end
      if (I_TX_VALID && O_TX_READY) begin
        next_c.tx_word = '{drive: I_TX_DRIVE, width: I_TX_WIDTH, data: I_TX_DATA};
        next_c.tx_tgl = !c.tx_tgl;
        next_c.busy = 1'h1;
      end
      if (rx_if.sync_out != c.rx_seen) begin
        next_c.rx_seen = rx_if.sync_out;
        next_c.rx_valid = 1'h1;
        next_c.rx_data = l.rx_byte;
      end
    end
    next_c.wp = !c.qe && !guard_pin;
    next_c.pause = !c.psel && !c.qe && !cs_high && !pause_pin;
    next_c.hw_rst = c.psel && (!c.qe || cs_high) && !pause_pin;
    next_c.selected = !cs_high;
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      c <= '0;
    end else if (I_CE) begin
      c <= next_c;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link domain, rising edge: sampling and phase loading

  spimio_width_e link_w;
  assign link_w = eff_width(l.width, c.qe);

  always_comb begin
    next_l = l;
    next_l.tx_s1 = c.tx_tgl;
    next_l.tx_s2 = l.tx_s1;
    if (l.tx_s2 != l.tx_seen) begin
      next_l.tx_seen = l.tx_s2;
      next_l.ack_tgl = l.tx_s2;
      next_l.drive = c.tx_word.drive;
      next_l.width = c.tx_word.width;
      next_l.tx_shift = c.tx_word.data;
      next_l.cnt = 4'h0;
    end else if (!o.hold) begin
      if (l.drive) begin
        next_l.tx_shift = l.tx_shift << step_of(link_w);
      end else begin
        next_l.rx_shift = shift_in(l.rx_shift, I_LANE, link_w);
        next_l.cnt = 4'(l.cnt + step_of(link_w));
        if (next_l.cnt == `SPIMIO_BYTE_BITS) begin
          next_l.cnt = 4'h0;
          next_l.rx_byte = next_l.rx_shift;
          next_l.rx_tgl = !l.rx_tgl;
        end
      end
    end
  end

  // Chip select high clears the frame at once; SCK may be stopped then
  always_ff @(posedge I_SCK or posedge I_CS_N) begin
    if (I_CS_N) begin
      l <= '0;
    end else begin
      l <= next_l;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link domain, falling edge: output change and pause

  always_comb begin
    next_o = o;
    next_o.bits = out_bits(l.tx_shift, link_w);
    // Enables move with the bits, so a new phase never shows stale data
    next_o.oe = {4{l.drive}} & mask_of(link_w);
    // Pause is only taken with SCK low, and never in quad or reset use
    next_o.hold = !c.psel && !c.qe && !I_LANE[`SPIMIO_LANE_THREE];
  end

  always_ff @(negedge I_SCK or posedge I_CS_N) begin
    if (I_CS_N) begin
      o <= '0;
    end else begin
      o <= next_o;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Raw chip select gates the drivers so release is immediate
  assign O_LANE_OE = {4{!I_CS_N && !o.hold}} & o.oe;
  assign O_LANE = o.bits;
  assign O_TX_READY = !c.busy && !cs_high;
  assign O_RX_VALID = c.rx_valid;
  assign O_RX_DATA = c.rx_data;
  assign O_WRITE_PROTECT = c.wp;
  assign O_PAUSE = c.pause;
  assign O_HW_RESET = c.hw_rst;
  assign O_SELECTED = c.selected;
endmodule // spimio_pin_mux

// ==== bench/spimio_pin_mux_assertions.sv ====
// Checker of the pin function selector, watching its top ports only.
// Assumes one core clock domain and I_CE held high by the bench.
`timescale 1ns/1ps
module spimio_pin_mux_assertions (
  // Core clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_SRST,
  // Link pins and configuration
  input wire logic I_SCK,
  input wire logic I_CS_N,
  input wire logic [3:0] O_LANE,
  input wire logic [3:0] O_LANE_OE,
  input wire logic I_QUAD_ENABLE,
  input wire logic I_PAUSE_OR_RESET_SELECT,
  // Handshake and status
  input wire logic I_TX_VALID,
  input wire logic O_TX_READY,
  input wire logic O_WRITE_PROTECT,
  input wire logic O_PAUSE,
  input wire logic O_HW_RESET,
  input wire logic O_SELECTED
);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (I_SRST);
  ////////////////////////////////////////////////////////////////////////////////
  float_off_a: assert property (I_CS_N |-> O_LANE_OE == 4'h0)
    else $error("lane driven while deselected");
  upper_quad_a: assert property (O_LANE_OE[3:2] != 2'h0 |-> I_QUAD_ENABLE)
    else $error("upper lanes driven outside quad mode");
  lane_pair_a: assert property (O_LANE_OE[0] |-> O_LANE_OE[1])
    else $error("lane zero driven without lane one");
  // Config is quasi-static, so status is judged only once it has settled
  wp_gone_a: assert property (
    I_QUAD_ENABLE && $past(I_QUAD_ENABLE, 4) |-> !O_WRITE_PROTECT)
    else $error("write guard active in quad mode");
  pause_gone_a: assert property (
    I_PAUSE_OR_RESET_SELECT && $past(I_PAUSE_OR_RESET_SELECT, 4) |-> !O_PAUSE)
    else $error("pause active while reset selected");
  rst_sel_a: assert property (
    !I_PAUSE_OR_RESET_SELECT && !$past(I_PAUSE_OR_RESET_SELECT, 4) |-> !O_HW_RESET)
    else $error("hardware reset without selection");
  lane_fall_a: assert property (
    ($changed(O_LANE) || $changed(O_LANE_OE)) && !I_CS_N |-> !I_SCK)
    else $error("lane output moved while clock high");
  desel_a: assert property (I_CS_N [*5] |-> !O_SELECTED && !O_TX_READY)
    else $error("selected while chip select high");
  take_once_a: assert property (I_TX_VALID && O_TX_READY |=> !O_TX_READY)
    else $error("ready held after a request was taken");
endmodule // spimio_pin_mux_assertions

bind spimio_pin_mux spimio_pin_mux_assertions i_chk (.*);

// ==== bench/spimio_host_model.sv ====
// Host side of the link: a behavioural SPI master with lane drivers.
// Assumes the bench resolves the lanes and feeds the levels back.
`timescale 1ns/1ps
module spimio_host_model (
  // Resolved lane levels
  input wire logic [3:0] i_io,
  // Link outputs
  output logic o_sck,
  output logic o_cs_n,
  output logic [3:0] o_drv,
  output logic [3:0] o_oe
);
  // Clock stands low between frames
  initial begin
    o_sck = 1'h0;
    o_cs_n = 1'h1;
    o_drv = 4'h0;
    o_oe = 4'h0;
  end
  task automatic set(input logic c, input logic [3:0] oe, input logic [3:0] dv);
    o_cs_n <= c;
    o_oe <= oe;
    o_drv <= dv;
  endtask
  // Odd offset keeps link edges off the core edges
  task automatic tick(output logic [3:0] smp);
    #31.3 o_sck = 1'h1;
    smp = i_io;
    #32 o_sck = 1'h0;
    #0.7;
  endtask
  task automatic xfer(input int s, input logic hd, input logic [7:0] d, output logic [7:0] q);
    logic [3:0] smp;
    q = 8'h00;
    o_oe = hd ? 4'hF >> (4 - s) : 4'h0;
    for (int i = 0; i < 8; i += s) begin
      o_drv = 4'(8'(d << i) >> (8 - s));
      tick(smp);
      q = 8'(q << s) | 8'(s == 1 ? smp[1] : smp & (4'hF >> (4 - s)));
    end
    o_oe = 4'h0;
  endtask
endmodule // spimio_host_model

// ==== bench/spimio_pin_mux_bench.sv ====
// Bench of the pin function selector with a host model on the link.
// Assumes the design, checker and host model are compiled before it.
`timescale 1ns/1ps
module spimio_pin_mux_bench;
  import spimio_pkg::*;
  logic clk = 1'h0, srst = 1'h1, qe = 1'h0, psel = 1'h0, tv = 1'h0, td = 1'h0, flip = 1'h0;
  spimio_width_e tw = SPIMIO_W_SINGLE;
  logic [7:0] tdat = 8'h00, rxq = 8'h00, rxd, hq;
  logic [3:0] lo, oe, io, hdrv, hoe, smp;
  logic sck, cs_n, rdy, rxv, wp, pz, hr, sel;
  integer n_fail = 0, cmp_count = 0, rx_n = 0, seed = 32'he5b7ad6b;
  always #2 clk = ~clk;
  always @(posedge clk) flip <= ~flip;
  // Released data lanes wander each cycle; the upper two have pull-ups
  assign io = (oe & lo) | (~oe & hoe & hdrv) | (~oe & ~hoe & {2'h3, flip, flip});
  always @(posedge clk) if (rxv === 1'h1) begin
    rxq <= rxd;
    rx_n <= rx_n + 1;
  end
  spimio_pin_mux i_dut (.I_CORE_CLK(clk), .I_SRST(srst), .I_CE(1'h1), .I_SCK(sck),
    .I_CS_N(cs_n), .I_LANE(io), .O_LANE(lo), .O_LANE_OE(oe), .I_QUAD_ENABLE(qe),
    .I_PAUSE_OR_RESET_SELECT(psel), .I_TX_VALID(tv), .I_TX_WIDTH(tw), .I_TX_DRIVE(td),
    .I_TX_DATA(tdat), .O_TX_READY(rdy), .O_RX_VALID(rxv), .O_RX_DATA(rxd),
    .O_WRITE_PROTECT(wp), .O_PAUSE(pz), .O_HW_RESET(hr), .O_SELECTED(sel));
  spimio_host_model h (.i_io(io), .o_sck(sck), .o_cs_n(cs_n), .o_drv(hdrv), .o_oe(hoe));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    if (n_fail == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] act, input logic [7:0] exp);
    cmp_count++;
    if (act !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t act=%h exp=%h", $time, act, exp);
    end
  endtask
  task automatic stuck(input bit c);
    if (c) begin
      n_fail++;
      give_verdict();
    end
  endtask
  task automatic wait_rdy;
    int k;
    for (k = 0; k < 40 && rdy !== 1'h1; k++) @(posedge clk);
    stuck(k == 40);
  endtask
  task automatic rx_chk(input int n0, input logic [7:0] e);
    int k;
    for (k = 0; k < 40 && rx_n == n0; k++) @(posedge clk);
    stuck(k == 40);
    check(rxq, e);
  endtask
  // The link loads a word only on link edges, so the host clocks until ready
  task automatic req(input spimio_width_e w, input logic d, input logic [7:0] v);
    int k;
    wait_rdy();
    tw <= w;
    td <= d;
    tdat <= v;
    tv <= 1'h1;
    @(posedge clk);
    tv <= 1'h0;
    for (k = 0; k < 10 && (k == 0 || rdy !== 1'h1); k++) h.tick(smp);
    wait_rdy();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] v;
    logic [3:0] m;
    int s, n0;
    repeat (10) @(posedge clk);
    srst <= 1'h0;
    for (int i = 0; i < 24; i++) begin
      h.set(1'h1, 4'h0, 4'h0);
      @(posedge clk);
      v = 8'($random(seed));
      qe <= v[3];
      psel <= v[4];
      repeat (4) @(posedge clk);
      h.set(v[0], 4'hC, {v[2:1], 2'h0});
      repeat (8) @(posedge clk);
      m = {!qe && !v[1], !psel && !qe && !v[0] && !v[2], psel && (!qe || v[0]) && !v[2], !v[0]};
      check({4'h0, wp, pz, hr, sel}, {4'h0, m});
    end
    for (int q = 0; q < 2; q++) begin
      @(posedge clk);
      h.set(1'h1, 4'h0, 4'h0);
      @(posedge clk);
      qe <= q[0];
      psel <= q[0];
      repeat (4) @(posedge clk);
      h.set(1'h0, 4'h0, 4'h0);
      wait_rdy();
      v = 8'($random(seed));
      n0 = rx_n;
      h.xfer(1, 1'h1, v, hq);
      rx_chk(n0, v);
      // Pause lands after one bit; the paused ticks and the release tick shift nothing
      if (q == 0) begin
        @(posedge clk);
        h.set(1'h0, 4'h9, 4'h1);
        h.tick(smp);
        check({7'h00, pz}, 8'h01);
        h.set(1'h0, 4'h9, 4'h0);
        repeat (3) h.tick(smp);
        h.set(1'h0, 4'h0, 4'h0);
        h.tick(smp);
        v = 8'($random(seed));
        n0 = rx_n;
        h.xfer(1, 1'h1, v, hq);
        rx_chk(n0, {1'h1, v[7:1]});
      end
      for (int j = 0; j < 6; j++) begin
        m = j < 2 ? 4'h2 : (j > 3 && q != 0) ? 4'hF : 4'h3;
        s = m == 4'h2 ? 1 : m == 4'h3 ? 2 : 4;
        v = j == 1 ? 8'hFF : 8'($random(seed));
        req(spimio_width_e'(j / 2), j[0], v);
        check({4'h0, oe}, j[0] ? {4'h0, m} : 8'h00);
        n0 = rx_n;
        h.xfer(s, !j[0], v, hq);
        if (j[0]) check(hq, v);
        else rx_chk(n0, v);
      end
    end
    @(posedge clk);
    h.set(1'h1, 4'h0, 4'h0);
    repeat (8) @(posedge clk);
    check({7'h00, sel}, 8'h00);
    check({4'h0, oe}, 8'h00);
    give_verdict();
  end
endmodule // spimio_pin_mux_bench
